// ==== rtl/dpac_pin_sync.sv ====
`timescale 1ns/1ps
// three-stage synchroniser; output moves once stages two and three agree
module dpac_pin_sync
  import dpac_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dpac_sync_t;
  dpac_sync_t st_q;
  dpac_sync_t st_d;
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.q[i] = st_q.s3[i];
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign q_o = st_q.q;
endmodule

// ==== rtl/dpac_pkg.sv ====
package dpac_pkg;
  // ==========================================================================
  // pin widths
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int FLAG_AW = 3;
  // ==========================================================================
  // access kinds taken at the user port
  typedef enum logic [2:0] {
    DPAC_OP_MEM_RD  = 3'h0,
    DPAC_OP_MEM_WR  = 3'h1,
    DPAC_OP_FLAG_RD = 3'h2,
    DPAC_OP_FLAG_WR = 3'h3
  } dpac_op_t;
  // ==========================================================================
  // controller states
  typedef enum logic [2:0] {
    DPAC_ST_IDLE  = 3'h0,
    DPAC_ST_SETUP = 3'h1,
    DPAC_ST_PULSE = 3'h2,
    DPAC_ST_HOLD  = 3'h3,
    DPAC_ST_DONE  = 3'h4
  } dpac_state_t;
  // ==========================================================================
  // timing (ns), derived cycle counts at 100 MHz
  localparam int CLK_NS     = 10;
  localparam int SETUP_NS   = 20;
  localparam int PULSE_NS   = 40;
  localparam int HOLD_NS    = 20;
  localparam int CNT_W      = 4;
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC  = CNT_W'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
  localparam int FLAG_BIT = 0;
endpackage

// ==== rtl/dpac_port_ctrl.sv ====
`timescale 1ns/1ps
// Operation
// [R1] chip select and flag select high deselect
// [R2] upper lane only write: upper select low
// [R3] lower lane write, both when both selected
// [R4] upper read drives upper, both if both
// [R5] lower only read drives lower byte
// [R6] flag read: flag select low, lanes off
// [R7] flag write loads bit 0 on rising write
// [R8] eight flags, written by data bit zero
// [R9] flag picked by three low address lines
// [R10] never flag select with chip and lane
// [R11] one controller per independent device port
// [R12] flags shared; other port sees them
module dpac_port_ctrl
  import dpac_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // user request
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire dpac_op_t          req_op_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic              req_upper_i,
  input  wire logic              req_lower_i,
  input  wire logic              req_flag_i,
  // user answer
  output logic                   rsp_valid_o,
  output logic      [DATA_W-1:0] rsp_rdata_o,
  // device port pins
  output logic                   chip_select_n_o,
  output logic                   read_write_o,
  output logic                   output_enable_n_o,
  output logic                   upper_lane_select_n_o,
  output logic                   lower_lane_select_n_o,
  output logic                   flag_space_select_n_o,
  output logic      [ADDR_W-1:0] addr_o,
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [DATA_W-1:0] data_o,
  output logic      [DATA_W-1:0] data_oe_o
);
  // ==========================================================================
  // state
  typedef struct packed {
    dpac_state_t       st;
    logic [CNT_W-1:0]  cnt;
    dpac_op_t          op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              upper;
    logic              lower;
    logic              cs_n;
    logic              rw;
    logic              oe_n;
    logic              ub_n;
    logic              lb_n;
    logic              sem_n;
    logic [DATA_W-1:0] oe;
    logic              rsp_v;
    logic [DATA_W-1:0] rdata;
  } dpac_ctrl_t;

  dpac_ctrl_t        s_q;
  dpac_ctrl_t        s_d;
  logic [DATA_W-1:0] data_sync;

  dpac_pin_sync #(.W(DATA_W)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (data_i),
    .q_o   (data_sync)
  );

  function automatic logic is_flag(input dpac_op_t op);
    return (op == DPAC_OP_FLAG_RD) || (op == DPAC_OP_FLAG_WR);
  endfunction

  function automatic logic is_write(input dpac_op_t op);
    return (op == DPAC_OP_MEM_WR) || (op == DPAC_OP_FLAG_WR);
  endfunction

  // lane enables for memory writes
  function automatic logic [DATA_W-1:0] lane_mask(input logic up, input logic lo);
    return {{BYTE_W{up}}, {BYTE_W{lo}}};
  endfunction

  // ==========================================================================
  // sequencer
  always_comb begin
    s_d       = s_q;
    s_d.rsp_v = 1'b0;
    case (s_q.st)
      DPAC_ST_IDLE: begin
        s_d.cs_n  = 1'b1; // [R1]
        s_d.sem_n = 1'b1; // [R1]
        s_d.ub_n  = 1'b1;
        s_d.lb_n  = 1'b1;
        s_d.oe_n  = 1'b1;
        s_d.rw    = 1'b1;
        s_d.oe    = '0;
        if (req_valid_i) begin
          s_d.op    = req_op_i;
          s_d.addr  = req_addr_i;
          s_d.wdata = req_wdata_i;
          s_d.upper = req_upper_i;
          s_d.lower = req_lower_i;
          s_d.cnt   = SETUP_CYC;
          s_d.st    = DPAC_ST_SETUP;
          if (is_flag(req_op_i)) begin
            // flag access keeps chip select and both lanes high
            s_d.addr  = ADDR_W'(req_addr_i[FLAG_AW-1:0]); // [R9]
            s_d.sem_n = 1'b0; // [R10] [R12]
            s_d.wdata = DATA_W'(req_wdata_i[FLAG_BIT]); // [R8]
          end else begin
            s_d.cs_n = 1'b0; // [R11]
            s_d.ub_n = ~req_upper_i; // [R2] [R4]
            s_d.lb_n = ~req_lower_i; // [R3] [R5]
          end
        end
      end
      DPAC_ST_SETUP: begin
        s_d.cnt = s_q.cnt - CNT_ONE;
        if (s_q.cnt == CNT_ONE) begin
          s_d.cnt = PULSE_CYC;
          s_d.st  = DPAC_ST_PULSE;
          if (is_write(s_q.op)) begin
            s_d.rw = 1'b0;
            if (is_flag(s_q.op)) begin
              s_d.oe = '1; // [R7]
            end else begin
              s_d.oe = lane_mask(s_q.upper, s_q.lower); // [R2] [R3]
            end
          end else begin
            s_d.oe_n = 1'b0; // [R4] [R5] [R6]
          end
        end
      end
      DPAC_ST_PULSE: begin
        s_d.cnt = s_q.cnt - CNT_ONE;
        if (s_q.cnt == CNT_ONE) begin
          s_d.cnt = HOLD_CYC;
          s_d.st  = DPAC_ST_HOLD;
          // rising read/write edge latches the flag bit
          s_d.rw   = 1'b1; // [R7]
          s_d.oe_n = 1'b1;
        end
      end
      DPAC_ST_HOLD: begin
        // data held past the rising edge, then released
        s_d.cnt = s_q.cnt - CNT_ONE;
        // synchroniser trails the pins by four edges: the read value is
        // settled on the same edge that lifts output enable
        if (s_q.cnt == HOLD_CYC && !is_write(s_q.op)) begin
          if (is_flag(s_q.op)) begin
            s_d.rdata = data_sync; // [R6] [R8]
          end else begin
            s_d.rdata = data_sync & lane_mask(s_q.upper, s_q.lower); // [R4] [R5]
          end
        end
        if (s_q.cnt == CNT_ONE) begin
          s_d.cnt   = CNT_ZERO;
          s_d.st    = DPAC_ST_DONE;
          s_d.oe    = '0;
          s_d.cs_n  = 1'b1; // [R1]
          s_d.sem_n = 1'b1;
          s_d.ub_n  = 1'b1;
          s_d.lb_n  = 1'b1;
        end
      end
      DPAC_ST_DONE: begin
        s_d.rsp_v = 1'b1;
        s_d.st    = DPAC_ST_IDLE;
      end
      default: begin
        s_d.st = DPAC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q       <= '0;
      s_q.st    <= DPAC_ST_IDLE;
      s_q.cs_n  <= 1'b1;
      s_q.rw    <= 1'b1;
      s_q.oe_n  <= 1'b1;
      s_q.ub_n  <= 1'b1;
      s_q.lb_n  <= 1'b1;
      s_q.sem_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs
  assign req_ready_o           = (s_q.st == DPAC_ST_IDLE);
  assign rsp_valid_o           = s_q.rsp_v;
  assign rsp_rdata_o           = s_q.rdata;
  assign chip_select_n_o       = s_q.cs_n;
  assign read_write_o          = s_q.rw;
  assign output_enable_n_o     = s_q.oe_n;
  assign upper_lane_select_n_o = s_q.ub_n;
  assign lower_lane_select_n_o = s_q.lb_n;
  assign flag_space_select_n_o = s_q.sem_n;
  assign addr_o                = s_q.addr;
  assign data_o                = s_q.wdata;
  assign data_oe_o             = s_q.oe;

  // ==========================================================================
  // checks
  chk_no_mixed_access: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    !(!s_q.sem_n && !s_q.cs_n)) else $error("flag and chip select both low");
  chk_flag_lanes_high: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    !s_q.sem_n |-> (s_q.ub_n && s_q.lb_n)) else $error("lane low in flag access");
  chk_idle_deselect: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (s_q.st == DPAC_ST_IDLE) |-> (s_q.cs_n && s_q.sem_n)) else $error("idle not deselected");
  chk_flag_addr_low: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    !s_q.sem_n |-> (s_q.addr[ADDR_W-1:FLAG_AW] == '0)) else $error("flag address high bits");
  chk_flag_data_bit: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    (!s_q.sem_n && !s_q.rw) |-> (s_q.wdata[DATA_W-1:1] == '0)) else $error("flag data upper bits");
  sequence seq_wr_low;
    !s_q.rw ##1 s_q.rw;
  endsequence
  chk_write_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    seq_wr_low |-> (s_q.oe != '0)) else $error("data released at write edge");
  chk_wr_no_oe: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    !s_q.rw |-> s_q.oe_n) else $error("output enable during write");
  chk_upper_lane: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (!s_q.rw && s_q.sem_n) |-> (s_q.oe == lane_mask(!s_q.ub_n, !s_q.lb_n)))
    else $error("write lanes do not match selects");
  chk_read_no_drive: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    !s_q.oe_n |-> (s_q.oe == '0)) else $error("driving during read");
  chk_rsp_after: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    (s_q.st == DPAC_ST_HOLD && s_q.cnt == CNT_ONE) |=> ##1 s_q.rsp_v)
    else $error("answer not given");
endmodule

// ==== tb/dpac_dev_model.sv ====
`timescale 1ns/1ps
// ====================
// device port: memory array and flags
module dpac_dev_model
  import dpac_pkg::*;
(
  // pattern clock
  input  wire logic              clk_i,
  // port pins
  input  wire logic              cs_n_i,
  input  wire logic              rw_i,
  input  wire logic              oe_n_i,
  input  wire logic              up_n_i,
  input  wire logic              lo_n_i,
  input  wire logic              flag_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] host_d_i,
  input  wire logic [DATA_W-1:0] host_oe_i,
  output logic      [DATA_W-1:0] data_o,
  output logic                   bad_o
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [7:0]        flags;
  logic [DATA_W-1:0] val, en, junk, wire_v;
  logic              rd_mem, rd_flag, off;
  initial junk = 16'h5555;
  initial bad_o = 1'b0;
  // released lines move every cycle so a stale value never passes
  always @(posedge clk_i) junk <= ~junk;
  assign off = up_n_i && lo_n_i;
  assign rd_mem = !cs_n_i && rw_i && !oe_n_i && flag_n_i;
  assign rd_flag = !flag_n_i && rw_i && !oe_n_i && (cs_n_i || off);
  assign val = rd_flag ? {DATA_W{flags[addr_i[FLAG_AW-1:0]]}} : mem[addr_i];
  assign en = rd_flag ? '1 : rd_mem ? {{BYTE_W{!up_n_i}}, {BYTE_W{!lo_n_i}}} : '0;
  assign data_o = (en & val) | (~en & junk);
  assign wire_v = (host_d_i & host_oe_i) | (~host_oe_i & junk);
  always @(posedge rw_i) begin
    if (flag_n_i === 1'b0 && (cs_n_i === 1'b1 || off === 1'b1))
      flags[addr_i[FLAG_AW-1:0]] <= wire_v[FLAG_BIT];
    else if (cs_n_i === 1'b0 && flag_n_i === 1'b1) begin
      if (!up_n_i) mem[addr_i][15:8] <= wire_v[15:8];
      if (!lo_n_i) mem[addr_i][7:0] <= wire_v[7:0];
    end
  end
  // forbidden select mix or contention is latched
  always @(posedge clk_i)
    if ((!flag_n_i && !cs_n_i && !off) || |(en & host_oe_i)) bad_o <= 1'b1;
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import dpac_pkg::*;
;
  logic              clk, rst, valid, ready, rsp, up, lo, bad;
  logic              cs_n, rw, oe_n, up_n, lo_n, flag_n;
  dpac_op_t          op;
  logic [ADDR_W-1:0] addr, pa;
  logic [DATA_W-1:0] wd, rd, din, dout, doe, q;
  int                n_fail, total_checks, i;
  dpac_port_ctrl u_dpac_port_ctrl (.clk_i(clk), .rst_i(rst), .req_valid_i(valid),
    .req_ready_o(ready), .req_op_i(op), .req_addr_i(addr), .req_wdata_i(wd),
    .req_upper_i(up), .req_lower_i(lo), .req_flag_i(1'b0), .rsp_valid_o(rsp),
    .rsp_rdata_o(rd), .chip_select_n_o(cs_n), .read_write_o(rw),
    .output_enable_n_o(oe_n), .upper_lane_select_n_o(up_n),
    .lower_lane_select_n_o(lo_n), .flag_space_select_n_o(flag_n), .addr_o(pa),
    .data_i(din), .data_o(dout), .data_oe_o(doe));
  dpac_dev_model u_dpac_dev_model (.clk_i(clk), .cs_n_i(cs_n), .rw_i(rw), .oe_n_i(oe_n),
    .up_n_i(up_n), .lo_n_i(lo_n), .flag_n_i(flag_n), .addr_i(pa), .host_d_i(dout),
    .host_oe_i(doe), .data_o(din), .bad_o(bad));
  // ====================
  // tasks
  task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input dpac_op_t o, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic u, l);
    int k;
    @(negedge clk);
    valid = 1'b1;
    op = o;
    addr = a;
    wd = d;
    up = u;
    lo = l;
    @(negedge clk);
    valid = 1'b0;
    check("ready busy", {15'h0000, ready}, 16'h0000);
    for (k = 0; k < 20 && rsp !== 1'b1; k++) @(negedge clk);
    if (k == 20) check("answer", 16'h0000, 16'h0001);
    q = rd;
  endtask
  task automatic end_sim();
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ====================
  // clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    check("watchdog", 16'h0000, 16'h0001);
    end_sim();
  end
  initial begin
    rst = 1'b1;
    valid = 1'b0;
    op = DPAC_OP_MEM_RD;
    addr = 12'h000;
    wd = 16'h0000;
    up = 1'b0;
    lo = 1'b0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    check("idle selects", {12'h000, cs_n, flag_n, up_n, lo_n}, 16'h000F);
    acc(DPAC_OP_MEM_WR, 12'h123, 16'hA5C3, 1'b1, 1'b1);
    acc(DPAC_OP_MEM_RD, 12'h123, 16'h0000, 1'b1, 1'b1);
    check("both bytes", q, 16'hA5C3);
    acc(DPAC_OP_MEM_WR, 12'h123, 16'h7E00, 1'b1, 1'b0);
    acc(DPAC_OP_MEM_WR, 12'h123, 16'h0055, 1'b0, 1'b1);
    acc(DPAC_OP_MEM_RD, 12'h123, 16'h0000, 1'b1, 1'b1);
    check("lane writes", q, 16'h7E55);
    acc(DPAC_OP_MEM_RD, 12'h123, 16'h0000, 1'b1, 1'b0);
    check("upper read", {q[15:8], 8'h00}, 16'h7E00);
    acc(DPAC_OP_MEM_RD, 12'h123, 16'h0000, 1'b0, 1'b1);
    check("lower read", {8'h00, q[7:0]}, 16'h0055);
    // parity pattern exposes any single wrong flag address bit
    for (i = 0; i < 8; i++)
      acc(DPAC_OP_FLAG_WR, {9'h1FF, i[2:0]}, {{15{~^i[2:0]}}, ^i[2:0]}, 1'b0, 1'b0);
    for (i = 0; i < 8; i++) begin
      acc(DPAC_OP_FLAG_RD, {9'h000, i[2:0]}, 16'h0000, 1'b0, 1'b0);
      check("flag", q, {16{^i[2:0]}});
    end
    acc(DPAC_OP_MEM_RD, 12'h123, 16'h0000, 1'b1, 1'b1);
    check("memory after flags", q, 16'h7E55);
    check("select mix", {15'h0000, bad}, 16'h0000);
    check("end selects", {12'h000, cs_n, flag_n, up_n, lo_n}, 16'h000F);
    end_sim();
  end
endmodule
